// [pkg/cma_defs.vh]
`ifndef CMA_DEFS_VH
`define CMA_DEFS_VH
// Stack geometry
`define CMA_STK_DEPTH 16
`define CMA_STK_PTR_W 5
`define CMA_PC_W 15
// Program memory
`define CMA_PM_AW 13
`define CMA_RESET_VEC 15'h0000
`define CMA_INT_VEC 15'h0004
// Data memory address split
`define CMA_DA_W 12
`define CMA_BANK_HI 11
`define CMA_BANK_LO 7
`define CMA_OFS_HI 6
// In-bank regions
`define CMA_OFS_INDF0 7'h00
`define CMA_OFS_INDF1 7'h01
`define CMA_OFS_PCL 7'h02
`define CMA_OFS_FLAGS 7'h03
`define CMA_OFS_P0L 7'h04
`define CMA_OFS_P0H 7'h05
`define CMA_OFS_P1L 7'h06
`define CMA_OFS_P1H 7'h07
`define CMA_OFS_BSR 7'h08
`define CMA_OFS_ACC 7'h09
`define CMA_OFS_PC_HIGH_LATCH 7'h0A
`define CMA_OFS_INTC 7'h0B
`define CMA_OFS_PER_LO 7'h0C
`define CMA_OFS_PER_HI 7'h1F
`define CMA_OFS_GPR_LO 7'h20
`define CMA_OFS_GPR_HI 7'h6F
`define CMA_OFS_COM_LO 7'h70
// Flag bits
`define CMA_F_C 0
`define CMA_F_DC 1
`define CMA_F_Z 2
`define CMA_F_PD 3
`define CMA_F_TO 4
`define CMA_FLAGS_RST 8'h18
`define CMA_PGM_BIT 7
`define CMA_GPR_BANKS 8
`endif

// [design/cma_core.v]
`timescale 1ns/1ps
// What this block does
// - Sixteen-entry fifteen-bit return stack, separate from data and program memory.
// - Stack overflow or underflow sets its flag and optionally requests software reset.
// - Two 16-bit indirect pointers reach all file registers and program memory.
// - Indirect port access to program memory takes one extra cycle.
// - Program counter is 15 bits, 32K words of 14 bits.
// - Program addresses beyond 8192 words wrap into implemented memory.
// - Reset starts at address 0000h; interrupts vector to 0004h.
// - Pointer high bit 7 reads program memory low byte; writes ignored.
// - Data memory is 32 banks of 128 bytes in four regions.
// - Direct accesses use bank last written into bank select register.
// - Unimplemented data locations read as zero.
// - Data addresses are 12 bits: bank field plus offset field.
// - Twelve core registers appear at first twelve addresses of every bank.
// - Peripheral registers occupy offsets 0Ch through 1Fh of each bank.
// - Flag-affecting ops to flag register keep result Z, DC, C.
// - Timeout and power-down bits read-only; bits 7-5 read zero.
// - Clearing flag register gives pattern 000u uluu.
// - Timeout bit set by power-up, watchdog clear, sleep; cleared by timeout.
// - Power-down bit set by power-up or watchdog clear; cleared by sleep.
// - Zero flag set when add or subtract result is zero; rotates leave it unchanged.
// - Digit carry set on carry out of bit 3 for add/subtract.
// - Carry is MSB carry; subtraction uses two's complement; rotates load carry.
`include "cma_defs.vh"
module cma_core (
  // Clock and reset
  input wire clock,
  input wire nrst,
  // Control flow
  input wire pc_step,
  input wire pc_load,
  input wire [14:0] pc_load_val,
  input wire call_push,
  input wire ret_pop,
  input wire int_entry,
  input wire stack_reset_en,
  // Data access
  input wire [6:0] dir_ofs,
  input wire acc_ind,
  input wire ind_sel,
  input wire rd_en,
  input wire wr_en,
  input wire [7:0] wr_data,
  input wire flag_clear_op,
  // Program memory data
  input wire [13:0] pm_rdata,
  // Result logic
  input wire alu_upd,
  input wire [1:0] alu_mode,
  input wire [7:0] alu_a,
  input wire [7:0] alu_b,
  input wire rot_in,
  // Watchdog events
  input wire watchdog_clear_op,
  input wire sleep_op,
  input wire watchdog_timeout,
  // Outputs
  output reg [14:0] pc_r,
  output reg [12:0] pm_addr_r,
  output reg [7:0] rd_data_r,
  output reg rd_valid_r,
  output reg stall_r,
  output reg [7:0] alu_flags_reset_cause_r,
  output reg [7:0] alu_result_r,
  output reg stack_overflow_flag_r,
  output reg stack_underflow_flag_r,
  output reg soft_reset_r,
  output reg [4:0] bank_select_reg_r,
  output reg [7:0] accumulator_reg_r
);
  localparam ST_IDLE = 1'b0;
  localparam ST_PGM = 1'b1;
  // Separate stack storage
  reg [14:0] stack_mem [0:`CMA_STK_DEPTH-1];
  reg [4:0] sp_r;
  reg [15:0] ptr_r [0:1];
  reg [7:0] pc_high_latch_r;
  reg [7:0] intc_r;
  reg [7:0] gpr_mem [0:(`CMA_GPR_BANKS*80)-1];
  reg [7:0] common_mem [0:15];
  reg state_r;
  reg [7:0] rd_nxt;
  reg [8:0] sum9;
  reg [4:0] sum5;
  reg [7:0] res;
  reg c_n, dc_n;
  wire [15:0] cur_ptr;
  wire [11:0] daddr;
  wire [4:0] bank;
  wire [6:0] ofs;
  wire [14:0] int_vec;
  integer i;

  assign cur_ptr = ptr_r[ind_sel];
  assign daddr = acc_ind ? cur_ptr[11:0] : {bank_select_reg_r, dir_ofs};
  assign bank = daddr[`CMA_BANK_HI:`CMA_BANK_LO];
  assign ofs = daddr[`CMA_OFS_HI:0];
  // Vector sliced to the fetch width, not silently truncated
  assign int_vec = `CMA_INT_VEC;

  // GENERAL_RAM index for implemented banks
  function [9:0] gpr_idx;
    input [4:0] b;
    input [6:0] o;
    begin
      gpr_idx = b[2:0] * 10'd80 + {3'b000, o - `CMA_OFS_GPR_LO};
    end
  endfunction

  always @* begin
    rd_nxt = 8'h00;
    if (ofs >= `CMA_OFS_COM_LO) begin
      rd_nxt = common_mem[ofs[3:0]];
    end else if (ofs >= `CMA_OFS_GPR_LO) begin
      if (bank < `CMA_GPR_BANKS) begin
        rd_nxt = gpr_mem[gpr_idx(bank, ofs)];
      end
    end else if (ofs < `CMA_OFS_PER_LO) begin
      case (ofs)
        `CMA_OFS_PCL: rd_nxt = pc_r[7:0];
        `CMA_OFS_FLAGS: rd_nxt = alu_flags_reset_cause_r;
        `CMA_OFS_P0L: rd_nxt = ptr_r[0][7:0];
        `CMA_OFS_P0H: rd_nxt = ptr_r[0][15:8];
        `CMA_OFS_P1L: rd_nxt = ptr_r[1][7:0];
        `CMA_OFS_P1H: rd_nxt = ptr_r[1][15:8];
        `CMA_OFS_BSR: rd_nxt = {3'b000, bank_select_reg_r};
        `CMA_OFS_ACC: rd_nxt = accumulator_reg_r;
        `CMA_OFS_PC_HIGH_LATCH: rd_nxt = pc_high_latch_r;
        `CMA_OFS_INTC: rd_nxt = intc_r;
        default: rd_nxt = 8'h00;
      endcase
    end
  end

  always @* begin
    sum9 = 9'h000;
    sum5 = 5'h00;
    res = 8'h00;
    c_n = alu_flags_reset_cause_r[`CMA_F_C];
    dc_n = alu_flags_reset_cause_r[`CMA_F_DC];
    case (alu_mode)
      2'b00: begin
        sum9 = {1'b0, alu_a} + {1'b0, alu_b};
        sum5 = {1'b0, alu_a[3:0]} + {1'b0, alu_b[3:0]};
        res = sum9[7:0];
        c_n = sum9[8];
        dc_n = sum5[4];
      end
      2'b01: begin
        // Add two's complement: carries act as inverted borrows
        sum9 = {1'b0, alu_a} + {1'b0, ~alu_b} + 9'h001;
        sum5 = {1'b0, alu_a[3:0]} + {1'b0, ~alu_b[3:0]} + 5'h01;
        res = sum9[7:0];
        c_n = sum9[8];
        dc_n = sum5[4];
      end
      2'b10: begin
        res = {alu_a[6:0], rot_in};
        c_n = alu_a[7];
      end
      default: begin
        res = {rot_in, alu_a[7:1]};
        c_n = alu_a[0];
      end
    endcase
  end

  always @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      pc_r <= `CMA_RESET_VEC;
      pm_addr_r <= 13'h0000;
      rd_data_r <= 8'h00;
      rd_valid_r <= 1'b0;
      stall_r <= 1'b0;
      alu_flags_reset_cause_r <= `CMA_FLAGS_RST;
      alu_result_r <= 8'h00;
      stack_overflow_flag_r <= 1'b0;
      stack_underflow_flag_r <= 1'b0;
      soft_reset_r <= 1'b0;
      bank_select_reg_r <= 5'h00;
      accumulator_reg_r <= 8'h00;
      sp_r <= 5'h00;
      ptr_r[0] <= 16'h0000;
      ptr_r[1] <= 16'h0000;
      pc_high_latch_r <= 8'h00;
      intc_r <= 8'h00;
      state_r <= ST_IDLE;
      for (i = 0; i < `CMA_STK_DEPTH; i = i + 1) begin
        stack_mem[i] <= 15'h0000;
      end
    end else begin
      rd_valid_r <= 1'b0;
      soft_reset_r <= 1'b0;
      case (state_r)
        ST_IDLE: begin
          if (acc_ind && cur_ptr[8+`CMA_PGM_BIT] && rd_en) begin
            pm_addr_r <= cur_ptr[12:0];
            stall_r <= 1'b1;
            state_r <= ST_PGM;
          end else if (rd_en) begin
            rd_data_r <= rd_nxt;
            rd_valid_r <= 1'b1;
          end
        end
        ST_PGM: begin
          // Low eight bits of the fetched word
          rd_data_r <= pm_rdata[7:0];
          rd_valid_r <= 1'b1;
          stall_r <= 1'b0;
          state_r <= ST_IDLE;
        end
        default: state_r <= ST_IDLE;
      endcase
      if (!stall_r) begin
        if (int_entry) begin
          pc_r <= `CMA_INT_VEC;
        end else if (pc_load) begin
          pc_r <= pc_load_val;
        end else if (pc_step) begin
          pc_r <= pc_r + 15'h0001;
        end
        if (!(acc_ind && cur_ptr[8+`CMA_PGM_BIT] && rd_en)) begin
          pm_addr_r <= int_entry ? int_vec[`CMA_PM_AW-1:0] : pc_r[`CMA_PM_AW-1:0];
        end
        if (call_push || int_entry) begin
          if (sp_r == `CMA_STK_DEPTH) begin
            stack_overflow_flag_r <= 1'b1;
            soft_reset_r <= stack_reset_en;
          end else begin
            stack_mem[sp_r[3:0]] <= pc_r;
            sp_r <= sp_r + 5'h01;
          end
        end else if (ret_pop) begin
          if (sp_r == 5'h00) begin
            stack_underflow_flag_r <= 1'b1;
            soft_reset_r <= stack_reset_en;
          end else begin
            pc_r <= stack_mem[sp_r[3:0] - 4'h1];
            sp_r <= sp_r - 5'h01;
          end
        end
      end
      if (alu_upd) begin
        alu_result_r <= res;
        accumulator_reg_r <= res;
      end
      // Direct and indirect writes; program memory writes dropped
      if (wr_en && !(acc_ind && cur_ptr[8+`CMA_PGM_BIT])) begin
        if (ofs >= `CMA_OFS_COM_LO) begin
          common_mem[ofs[3:0]] <= wr_data;
        end else if (ofs >= `CMA_OFS_GPR_LO) begin
          if (bank < `CMA_GPR_BANKS) begin
            gpr_mem[gpr_idx(bank, ofs)] <= wr_data;
          end
        end else begin
          case (ofs)
            `CMA_OFS_P0L: ptr_r[0][7:0] <= wr_data;
            `CMA_OFS_P0H: ptr_r[0][15:8] <= wr_data;
            `CMA_OFS_P1L: ptr_r[1][7:0] <= wr_data;
            `CMA_OFS_P1H: ptr_r[1][15:8] <= wr_data;
            `CMA_OFS_BSR: bank_select_reg_r <= wr_data[4:0];
            `CMA_OFS_ACC: accumulator_reg_r <= wr_data;
            `CMA_OFS_PC_HIGH_LATCH: pc_high_latch_r <= wr_data;
            `CMA_OFS_INTC: intc_r <= wr_data;
            default: begin
            end
          endcase
        end
      end
      if (wr_en && ofs == `CMA_OFS_FLAGS && !(acc_ind && cur_ptr[8+`CMA_PGM_BIT])) begin
        if (flag_clear_op) begin
          alu_flags_reset_cause_r[`CMA_F_Z] <= 1'b1;
        end else if (!alu_upd) begin
          alu_flags_reset_cause_r[2:0] <= wr_data[2:0];
        end
      end
      if (alu_upd) begin
        alu_flags_reset_cause_r[`CMA_F_C] <= c_n;
        if (alu_mode[1] == 1'b0) begin
          alu_flags_reset_cause_r[`CMA_F_DC] <= dc_n;
          alu_flags_reset_cause_r[`CMA_F_Z] <= (res == 8'h00);
        end
      end
      if (watchdog_timeout) begin
        alu_flags_reset_cause_r[`CMA_F_TO] <= 1'b0;
      end else if (watchdog_clear_op || sleep_op) begin
        alu_flags_reset_cause_r[`CMA_F_TO] <= 1'b1;
      end
      if (sleep_op) begin
        alu_flags_reset_cause_r[`CMA_F_PD] <= 1'b0;
      end else if (watchdog_clear_op) begin
        alu_flags_reset_cause_r[`CMA_F_PD] <= 1'b1;
      end
    end
  end
endmodule

// [testbench/cma_core_monitor.sv]
`timescale 1ns/1ps
module cma_core_monitor (
  // Clock and reset
  input wire clock,
  input wire nrst,
  // Requests
  input wire alu_upd,
  input wire [1:0] alu_mode,
  input wire [7:0] alu_a,
  input wire [7:0] alu_b,
  input wire watchdog_timeout,
  input wire watchdog_clear_op,
  input wire sleep_op,
  input wire rd_en,
  input wire acc_ind,
  // Answers
  input wire stall_r,
  input wire rd_valid_r,
  input wire [7:0] alu_flags_reset_cause_r,
  input wire stack_overflow_flag_r,
  input wire stack_underflow_flag_r,
  input wire soft_reset_r
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!nrst);
  upper_bits_zero_a: assert property (alu_flags_reset_cause_r[7:5] == 3'h0) else $error("flag top bits set");
  timeout_clears_a: assert property (watchdog_timeout |=> !alu_flags_reset_cause_r[4]) else $error("timeout bit kept");
  sleep_marks_a: assert property (sleep_op && !watchdog_timeout |=> alu_flags_reset_cause_r[4:3] == 2'h2)
    else $error("sleep status wrong");
  wdt_clear_a: assert property (watchdog_clear_op && !watchdog_timeout && !sleep_op
    |=> alu_flags_reset_cause_r[4:3] == 2'h3) else $error("clear status wrong");
  ovf_sticky_a: assert property (stack_overflow_flag_r |=> stack_overflow_flag_r) else $error("overflow lost");
  unf_sticky_a: assert property (stack_underflow_flag_r |=> stack_underflow_flag_r) else $error("underflow lost");
  soft_reset_cause_a: assert property (soft_reset_r |-> stack_overflow_flag_r || stack_underflow_flag_r)
    else $error("stray soft reset");
  fetch_stall_a: assert property (stall_r |=> !stall_r && rd_valid_r) else $error("fetch stall wrong");
  direct_read_a: assert property (rd_en && !acc_ind && !stall_r |=> rd_valid_r) else $error("read late");
  zero_flag_a: assert property (alu_upd && alu_mode == 2'h0 && ((alu_a + alu_b) & 8'hFF) == 8'h00
    |=> alu_flags_reset_cause_r[2]) else $error("zero flag clear");
endmodule
bind cma_core cma_core_monitor u_mon (.clock, .nrst, .alu_upd, .alu_mode, .alu_a, .alu_b, .watchdog_timeout,
  .watchdog_clear_op, .sleep_op, .rd_en, .acc_ind, .stall_r, .rd_valid_r, .alu_flags_reset_cause_r,
  .stack_overflow_flag_r, .stack_underflow_flag_r, .soft_reset_r);

// [testbench/cma_pm_model.sv]
`timescale 1ns/1ps
module cma_pm_model (
  // Fetch side
  input wire [12:0] pm_addr,
  output wire [13:0] pm_rdata
);
  // one word per address
  // Inverted address, so a zero or stale word cannot match
  assign pm_rdata = {1'h0, ~pm_addr};
endmodule

// [testbench/tb_cma_core.sv]
`timescale 1ns/1ps
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin error_cnt++; $display("unexpected %s %h %h", n, e, g); end end
module tb_cma_core;
  reg clock = 1'h0;
  reg nrst = 1'h0;
  reg pc_step, pc_load, call_push, ret_pop, int_entry, stack_reset_en, acc_ind, ind_sel, rd_en, wr_en;
  reg flag_clear_op, alu_upd, rot_in, watchdog_clear_op, sleep_op, watchdog_timeout;
  reg [14:0] pc_load_val;
  reg [6:0] dir_ofs;
  reg [7:0] wr_data, alu_a, alu_b;
  reg [1:0] alu_mode;
  wire [13:0] pm_rdata;
  wire [14:0] pc_r;
  wire [12:0] pm_addr_r;
  wire [7:0] rd_data_r, alu_flags_reset_cause_r, alu_result_r, accumulator_reg_r;
  wire rd_valid_r, stall_r, stack_overflow_flag_r, stack_underflow_flag_r, soft_reset_r;
  wire [4:0] bank_select_reg_r;
  integer error_cnt = 0, compares = 0, cyc = 0, i;
  always #50 clock = ~clock;
  cma_core u_dut (.clock, .nrst, .pc_step, .pc_load, .pc_load_val, .call_push, .ret_pop, .int_entry,
    .stack_reset_en, .dir_ofs, .acc_ind, .ind_sel, .rd_en, .wr_en, .wr_data, .flag_clear_op, .pm_rdata, .alu_upd,
    .alu_mode, .alu_a, .alu_b, .rot_in, .watchdog_clear_op, .sleep_op, .watchdog_timeout, .pc_r, .pm_addr_r,
    .rd_data_r, .rd_valid_r, .stall_r, .alu_flags_reset_cause_r, .alu_result_r, .stack_overflow_flag_r,
    .stack_underflow_flag_r, .soft_reset_r, .bank_select_reg_r, .accumulator_reg_r);
  cma_pm_model u_pm (.pm_addr(pm_addr_r), .pm_rdata);
  task wrap_up;
    begin
      $display("compares %0d mismatches %0d", compares, error_cnt);
      if (error_cnt == 0 && compares > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
    end
  endtask
  // Hang guard, tests need about 120 cycles
  always @(posedge clock) begin
    cyc = cyc + 1;
    if (cyc == 2000) begin
      error_cnt++;
      wrap_up;
    end
  end
  task wr(input [6:0] o, input [7:0] d, input ind, input clr);
    begin
      @(negedge clock);
      dir_ofs = o;
      wr_data = d;
      acc_ind = ind;
      flag_clear_op = clr;
      wr_en = 1'h1;
      @(negedge clock);
      {wr_en, flag_clear_op, acc_ind} = 3'h0;
    end
  endtask
  task rd(input [6:0] o, input ind, input [7:0] e);
    begin
      @(negedge clock);
      dir_ofs = o;
      acc_ind = ind;
      rd_en = 1'h1;
      @(negedge clock);
      rd_en = 1'h0;
      for (i = 0; i < 4 && rd_valid_r !== 1'h1; i++) @(negedge clock);
      acc_ind = 1'h0;
      `CHK("rd_wait", ind, i)
      `CHK("rd_data", e, rd_data_r)
    end
  endtask
  // Optional flag write in the same cycle as the result update
  task alu(input [1:0] m, input [7:0] a, b, input r, input [7:0] er, input [2:0] ef, input w);
    begin
      @(negedge clock);
      {alu_mode, alu_a, alu_b, rot_in, wr_en, dir_ofs, wr_data} = {m, a, b, r, w, 7'h03, 8'h00};
      alu_upd = 1'h1;
      @(negedge clock);
      {alu_upd, wr_en} = 2'h0;
      `CHK("alu_result", er, alu_result_r)
      `CHK("alu_flags", ef, alu_flags_reset_cause_r[2:0])
    end
  endtask
  task ev(input [2:0] v, input [1:0] e);
    begin
      @(negedge clock);
      {watchdog_timeout, sleep_op, watchdog_clear_op} = v;
      @(negedge clock);
      {watchdog_timeout, sleep_op, watchdog_clear_op} = 3'h0;
      `CHK("status", e, alu_flags_reset_cause_r[4:3])
    end
  endtask
  initial begin
    {pc_step, pc_load, call_push, ret_pop, int_entry, stack_reset_en, acc_ind, rd_en, wr_en} = 9'h000;
    {flag_clear_op, alu_upd, rot_in, watchdog_clear_op, sleep_op, watchdog_timeout} = 6'h00;
    {pc_load_val, dir_ofs, wr_data, alu_a, alu_b, alu_mode} = 48'h0;
    ind_sel = 1'h1;
    repeat (3) @(negedge clock);
    nrst = 1'h1;
    `CHK("pc", 15'h0000, pc_r)
    `CHK("flags", 8'h18, alu_flags_reset_cause_r)
    $display("reset test done");
    stack_reset_en = 1'h1;
    call_push = 1'h1;
    repeat (16) @(negedge clock);
    `CHK("overflow", 1'h0, stack_overflow_flag_r)
    @(negedge clock);
    call_push = 1'h0;
    `CHK("overflow", 1'h1, stack_overflow_flag_r)
    `CHK("soft_reset", 1'h1, soft_reset_r)
    stack_reset_en = 1'h0;
    ret_pop = 1'h1;
    repeat (16) @(negedge clock);
    `CHK("underflow", 1'h0, stack_underflow_flag_r)
    @(negedge clock);
    ret_pop = 1'h0;
    `CHK("underflow", 1'h1, stack_underflow_flag_r)
    `CHK("soft_reset", 1'h0, soft_reset_r)
    $display("stack test done");
    {pc_load_val, pc_load} = {15'h3FFF, 1'h1};
    @(negedge clock);
    {pc_load, pc_step} = 2'h1;
    @(negedge clock);
    pc_step = 1'h0;
    `CHK("pc", 15'h4000, pc_r)
    @(negedge clock);
    `CHK("pm_addr", 13'h0000, pm_addr_r)
    int_entry = 1'h1;
    @(negedge clock);
    int_entry = 1'h0;
    `CHK("pc", 15'h0004, pc_r)
    $display("pc test done");
    wr(7'h08, 8'h03, 0, 0);
    `CHK("bank", 5'h03, bank_select_reg_r)
    wr(7'h20, 8'hA5, 0, 0);
    wr(7'h70, 8'h3C, 0, 0);
    wr(7'h09, 8'h5A, 0, 0);
    `CHK("acc", 8'h5A, accumulator_reg_r)
    wr(7'h0C, 8'hFF, 0, 0);
    rd(7'h20, 0, 8'hA5);
    wr(7'h08, 8'h09, 0, 0);
    rd(7'h20, 0, 8'h00);
    rd(7'h70, 0, 8'h3C);
    rd(7'h09, 0, 8'h5A);
    rd(7'h0C, 0, 8'h00);
    wr(7'h08, 8'h02, 0, 0);
    wr(7'h34, 8'h55, 0, 0);
    wr(7'h07, 8'h81, 0, 0);
    wr(7'h06, 8'h34, 0, 0);
    rd(7'h07, 0, 8'h81);
    wr(7'h00, 8'h11, 1, 0);
    rd(7'h00, 1, 8'hCB);
    rd(7'h34, 0, 8'h55);
    ind_sel = 1'h0;
    wr(7'h05, 8'h80, 0, 0);
    wr(7'h04, 8'h12, 0, 0);
    rd(7'h01, 1, 8'hED);
    ind_sel = 1'h1;
    $display("memory test done");
    wr(7'h03, 8'hE7, 0, 0);
    rd(7'h03, 0, 8'h1F);
    wr(7'h03, 8'h03, 0, 0);
    wr(7'h03, 8'h00, 0, 1);
    rd(7'h03, 0, 8'h1F);
    alu(2'h0, 8'h0F, 8'h01, 0, 8'h10, 3'h2, 0);
    alu(2'h0, 8'hFF, 8'h01, 0, 8'h00, 3'h7, 0);
    alu(2'h1, 8'h03, 8'h05, 0, 8'hFE, 3'h0, 0);
    alu(2'h0, 8'hFF, 8'h01, 0, 8'h00, 3'h7, 1);
    alu(2'h1, 8'h03, 8'h05, 0, 8'hFE, 3'h0, 0);
    alu(2'h2, 8'h81, 8'h00, 0, 8'h02, 3'h1, 0);
    alu(2'h3, 8'h02, 8'h00, 1, 8'h81, 3'h0, 0);
    $display("flag test done");
    ev(3'h4, 2'h1);
    ev(3'h1, 2'h3);
    ev(3'h2, 2'h2);
    $display("status test done");
    wrap_up;
  end
endmodule
